// *** hdl/flsh_ahb.v ***
// AHB-Lite slave front end: captures the address phase and turns it into
// a write pulse in the data phase or a read fetch cycle.
// Assumes it is the only slave, so its hreadyout is the bus hready.
`timescale 1ns/100ps
module flsh_ahb (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       hsel,
  input  wire [1:0] htrans,
  input  wire       hwrite,
  input  wire [7:0] haddr,
  output wire       wr_en,
  output wire       rd_en,
  output reg  [7:0] reg_addr,
  output reg        hreadyout,
  output reg        hresp
);
  reg wr_ph;
  reg rd_ph;
  // Reads take one wait state so that a read right after a write sees it.
  wire take = hsel & htrans[1] & hreadyout;

  assign wr_en = wr_ph;
  assign rd_en = rd_ph;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_addr  <= 8'h00;
      wr_ph     <= 1'b0;
      rd_ph     <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (take) begin
      reg_addr  <= haddr;
      wr_ph     <= hwrite;
      rd_ph     <= ~hwrite;
      hreadyout <= hwrite;
    end else begin
      wr_ph     <= 1'b0;
      rd_ph     <= 1'b0;
      hreadyout <= 1'b1;
    end
  end
endmodule

// *** hdl/flsh_ctrl.v ***
// Host controller for an asynchronous boot-block flash: software orders
// whole command sequences over AHB-Lite and the block drives the pins.
// Assumes the flash pins are sampled synchronously to hclk.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "flsh_regs.vh"

module flsh_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg         deep_sleep_pin_n,
  output reg         program_supply_high_level,
  output reg         unlock_high_voltage,
  output reg         chip_sel_n,
  output reg         out_gate_n,
  output reg         wr_strobe_n,
  output reg  [16:0] flash_addr,
  output reg  [7:0]  flash_dq_o,
  output reg         flash_dq_oe,
  input  wire [7:0]  flash_dq_i
);
  localparam [2:0] E_IDLE   = 3'd0;
  localparam [2:0] E_WAIT   = 3'd1;
  localparam [2:0] E_SETUP  = 3'd2;
  localparam [2:0] E_STROBE = 3'd3;
  localparam [2:0] E_HOLD   = 3'd4;
  localparam [2:0] E_GAP    = 3'd5;

  localparam [7:0] WP_CYC   = `FLSH_WP_CYC;
  localparam [7:0] ACC_CYC  = `FLSH_ACC_CYC;
  localparam [7:0] HOLD_CYC = `FLSH_HOLD_CYC;
  localparam [7:0] GAP_CYC  = `FLSH_GAP_CYC;
  localparam [7:0] WAKE_CYC = `FLSH_WAKE_CYC;

  wire       wr_en;
  wire       rd_en;
  wire [7:0] reg_addr;
  wire       ph_exp;
  wire       wake_exp;

  reg [16:0] addr_reg;
  reg [7:0]  wdata_reg;
  reg [3:0]  op;
  reg        busy;
  reg        done;
  reg        err;
  reg [7:0]  rd_byte;
  reg [7:0]  stat_byte;
  reg [2:0]  est;
  reg [1:0]  step;
  reg        polling;
  reg        ph_load;
  reg [7:0]  ph_val;

  // One sequence entry: {last, read, use address, data byte}.
  function [10:0] seq_entry;
    input [3:0] f_op;
    input [1:0] f_step;
    begin
      seq_entry = {3'b100, `FLSH_FC_READ_ARRAY};
      case (f_op)
        `FLSH_OP_RESET:
          seq_entry = {3'b100, `FLSH_FC_READ_ARRAY};
        `FLSH_OP_READ:
          seq_entry = {3'b111, 8'h00};
        `FLSH_OP_PROG:
          if (f_step == 2'd0)
            seq_entry = {3'b001, `FLSH_FC_PROG_SETUP};
          else
            seq_entry = {3'b101, wdata_reg};
        `FLSH_OP_ERASE:
          if (f_step == 2'd0)
            seq_entry = {3'b001, `FLSH_FC_ERASE};
          else
            seq_entry = {3'b101, `FLSH_FC_CONFIRM};
        `FLSH_OP_RDSTAT:
          if (f_step == 2'd0)
            seq_entry = {3'b000, `FLSH_FC_RD_STATUS};
          else
            seq_entry = {3'b110, 8'h00};
        `FLSH_OP_CLRSTAT:
          seq_entry = {3'b100, `FLSH_FC_CLR_STATUS};
        `FLSH_OP_SUSPEND:
          seq_entry = {3'b100, `FLSH_FC_SUSPEND};
        `FLSH_OP_RESUME:
          seq_entry = {3'b100, `FLSH_FC_CONFIRM};
        `FLSH_OP_READID:
          if (f_step == 2'd0)
            seq_entry = {3'b000, `FLSH_FC_SIGNATURE};
          else
            seq_entry = {3'b111, 8'h00};
        `FLSH_OP_RAW:
          seq_entry = {3'b101, wdata_reg};
        default:
          seq_entry = {3'b100, `FLSH_FC_READ_ARRAY};
      endcase
    end
  endfunction

  wire [10:0] ent      = seq_entry(op, step);
  wire        ent_last = ent[10];
  wire        cur_rd   = polling | ent[9];
  wire [16:0] cur_addr = (polling | ~ent[8]) ? 17'h00000 : addr_reg;
  // Program, erase, suspend and resume end by polling the ready flag.
  wire        poll_op  = (op == `FLSH_OP_PROG) | (op == `FLSH_OP_ERASE) |
                         (op == `FLSH_OP_SUSPEND) |
                         (op == `FLSH_OP_RESUME);
  wire        awake    = deep_sleep_pin_n & wake_exp;

  wire        ctrl_wr  = wr_en & (reg_addr == `FLSH_REG_CTRL);
  wire        cmd_wr   = wr_en & (reg_addr == `FLSH_REG_CMD);
  wire [3:0]  new_op   = hwdata[3:0];
  // Program, erase and resume without the high supply would only abort inside.
  wire        need_vpp = (new_op == `FLSH_OP_PROG) |
                         (new_op == `FLSH_OP_ERASE) |
                         (new_op == `FLSH_OP_RESUME);
  wire        bad_op   = (new_op > `FLSH_OP_RAW) |
                         (need_vpp & ~program_supply_high_level);
  // Any change of the supply or wake pins restarts the settle wait.
  wire        wake_load = ctrl_wr &
    (hwdata[2:0] != {unlock_high_voltage, program_supply_high_level,
                     ~deep_sleep_pin_n});

  flsh_ahb u_ahb (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .haddr     (haddr[7:0]),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .reg_addr  (reg_addr),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  flsh_timer #(.W(8)) u_phase (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (ph_load),
    .load_val (ph_val),
    .expired  (ph_exp)
  );

  flsh_timer #(.W(8)) u_wake (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (wake_load),
    .load_val (WAKE_CYC),
    .expired  (wake_exp)
  );

  always @* begin
    ph_load = 1'b0;
    ph_val  = WP_CYC;
    case (est)
      E_SETUP: begin
        ph_load = 1'b1;
        ph_val  = cur_rd ? ACC_CYC : WP_CYC;
      end
      E_STROBE: begin
        ph_load = ph_exp;
        ph_val  = HOLD_CYC;
      end
      E_HOLD: begin
        ph_load = ph_exp;
        ph_val  = GAP_CYC;
      end
      default: begin
        ph_load = 1'b0;
        ph_val  = WP_CYC;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_en) begin
      case (reg_addr)
        `FLSH_REG_CTRL:
          hrdata <= {29'h00000000, unlock_high_voltage,
                     program_supply_high_level, ~deep_sleep_pin_n};
        `FLSH_REG_ADDR:  hrdata <= {15'h0000, addr_reg};
        `FLSH_REG_WDATA: hrdata <= {24'h000000, wdata_reg};
        `FLSH_REG_CMD:
          hrdata <= {24'h000000, op, awake, err, done, busy};
        `FLSH_REG_RDATA: hrdata <= {16'h0000, stat_byte, rd_byte};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deep_sleep_pin_n          <= ~`FLSH_CTRL_RST_SLEEP;
      program_supply_high_level <= 1'b0;
      unlock_high_voltage       <= 1'b0;
      addr_reg                  <= 17'h00000;
      wdata_reg                 <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        deep_sleep_pin_n          <= ~hwdata[`FLSH_CTRL_SLEEP];
        program_supply_high_level <= hwdata[`FLSH_CTRL_VPP];
        unlock_high_voltage       <= hwdata[`FLSH_CTRL_UNLOCK];
      end
      if (wr_en && reg_addr == `FLSH_REG_ADDR)
        addr_reg <= hwdata[16:0];
      if (wr_en && reg_addr == `FLSH_REG_WDATA)
        wdata_reg <= hwdata[7:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op          <= `FLSH_OP_RESET;
      busy        <= 1'b0;
      done        <= 1'b0;
      err         <= 1'b0;
      rd_byte     <= 8'h00;
      stat_byte   <= 8'h00;
      est         <= E_IDLE;
      step        <= 2'd0;
      polling     <= 1'b0;
      chip_sel_n  <= 1'b1;
      out_gate_n  <= 1'b1;
      wr_strobe_n <= 1'b1;
      flash_addr  <= 17'h00000;
      flash_dq_o  <= 8'h00;
      flash_dq_oe <= 1'b0;
    end else if (est != E_IDLE && !deep_sleep_pin_n) begin
      // Going to sleep mid-sequence aborts it; chip select, both strobes and the data bus are released.
      chip_sel_n  <= 1'b1;
      out_gate_n  <= 1'b1;
      wr_strobe_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      est         <= E_IDLE;
      busy        <= 1'b0;
      done        <= 1'b1;
      err         <= 1'b1;
    end else begin
      case (est)
        E_IDLE: begin
          if (cmd_wr) begin
            op      <= new_op;
            step    <= 2'd0;
            polling <= 1'b0;
            done    <= bad_op;
            err     <= bad_op;
            busy    <= ~bad_op;
            est     <= bad_op ? E_IDLE : E_WAIT;
          end
        end
        E_WAIT: begin
          if (awake) begin
            // Strobes stay high until the wake settle time is over.
            chip_sel_n  <= 1'b0;
            flash_addr  <= cur_addr;
            flash_dq_o  <= ent[7:0];
            flash_dq_oe <= ~cur_rd;
            est         <= E_SETUP;
          end
        end
        E_SETUP: begin
          if (cur_rd)
            out_gate_n  <= 1'b0;
          else
            wr_strobe_n <= 1'b0;
          est <= E_STROBE;
        end
        E_STROBE: begin
          if (ph_exp) begin
            out_gate_n  <= 1'b1;
            wr_strobe_n <= 1'b1;
            if (cur_rd) begin
              if (polling || op == `FLSH_OP_RDSTAT)
                stat_byte <= flash_dq_i;
              else
                rd_byte   <= flash_dq_i;
            end
            est <= E_HOLD;
          end
        end
        E_HOLD: begin
          if (ph_exp) begin
            // Address and data are held past the strobe's rising edge.
            flash_dq_oe <= 1'b0;
            chip_sel_n  <= 1'b1;
            est         <= E_GAP;
          end
        end
        E_GAP: begin
          if (ph_exp) begin
            if (polling) begin
              if (stat_byte[`FLSH_SR_READY]) begin
                // Status now valid; software may drop the supply.
                polling <= 1'b0;
                busy    <= 1'b0;
                done    <= 1'b1;
                est     <= E_IDLE;
              end else begin
                est <= E_WAIT;
              end
            end else if (ent_last) begin
              if (poll_op) begin
                // The status read follows the write with no pause.
                polling <= 1'b1;
                est     <= E_WAIT;
              end else begin
                busy <= 1'b0;
                done <= 1'b1;
                est  <= E_IDLE;
              end
            end else begin
              step <= step + 2'd1;
              est  <= E_WAIT;
            end
          end
        end
        default: begin
          est <= E_IDLE;
        end
      endcase
    end
  end
endmodule

// *** hdl/flsh_regs.vh ***
// Constants of the boot-block flash host controller: register offsets,
// field positions, reset values, operation codes and pin timing.
// Assumes a 100 MHz controller clock; all times are in nanoseconds.
`ifndef FLSH_REGS_VH
`define FLSH_REGS_VH

`define FLSH_CLK_MHZ       100

`define FLSH_T_WP_NS       40
`define FLSH_T_ACC_NS      120
`define FLSH_T_HOLD_NS     10
`define FLSH_T_WC_NS       120
`define FLSH_T_PS_NS       480
`define FLSH_T_PWH_NS      600
`define FLSH_T_VPS_NS      100

// The times above rounded up to whole cycles, sized for the 8-bit timers.
`define FLSH_WP_CYC        8'h04
`define FLSH_ACC_CYC       8'h0C
`define FLSH_HOLD_CYC      8'h01
// Rest of the write cycle time after strobe, hold and select cycles.
`define FLSH_GAP_CYC       8'h06
`define FLSH_WAKE_CYC      8'h3C

`define FLSH_REG_CTRL      8'h00
`define FLSH_REG_ADDR      8'h04
`define FLSH_REG_WDATA     8'h08
`define FLSH_REG_CMD       8'h0C
`define FLSH_REG_RDATA     8'h10

`define FLSH_CTRL_SLEEP    0
`define FLSH_CTRL_VPP      1
`define FLSH_CTRL_UNLOCK   2
`define FLSH_CTRL_RST      3'h1
`define FLSH_CTRL_RST_SLEEP 1'h1

`define FLSH_ST_BUSY       0
`define FLSH_ST_DONE       1
`define FLSH_ST_ERR        2
`define FLSH_ST_READY      3

`define FLSH_OP_RESET      4'h0
`define FLSH_OP_READ       4'h1
`define FLSH_OP_PROG       4'h2
`define FLSH_OP_ERASE      4'h3
`define FLSH_OP_RDSTAT     4'h4
`define FLSH_OP_CLRSTAT    4'h5
`define FLSH_OP_SUSPEND    4'h6
`define FLSH_OP_RESUME     4'h7
`define FLSH_OP_READID     4'h8
`define FLSH_OP_RAW        4'h9

`define FLSH_FC_READ_ARRAY 8'hFF
`define FLSH_FC_PROG_SETUP 8'h40
`define FLSH_FC_RD_STATUS  8'h70
`define FLSH_FC_CLR_STATUS 8'h50
`define FLSH_FC_ERASE      8'h20
`define FLSH_FC_CONFIRM    8'hD0
`define FLSH_FC_SUSPEND    8'hB0
`define FLSH_FC_SIGNATURE  8'h90
`define FLSH_SR_READY      7

`endif

// *** hdl/flsh_timer.v ***
// Down counter that raises expired a given number of cycles after a load.
// Assumes load_val is at least one.
`timescale 1ns/100ps
module flsh_timer #(
  parameter W = 8
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output reg          expired
);
  reg [W-1:0] cnt;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt     <= {W{1'b0}};
      expired <= 1'b0;
    end else if (load) begin
      cnt     <= load_val;
      expired <= 1'b0;
    end else if (cnt > {{(W-1){1'b0}}, 1'b1}) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end else begin
      cnt     <= {W{1'b0}};
      expired <= 1'b1;
    end
  end
endmodule

// *** tb/flsh_chk.sv ***
// Checker of the flash host controller: pin order and bus answers.
// Bound to flsh_ctrl; one clock domain, sees only its ports.
`timescale 1ns/100ps
module flsh_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hreadyout,
  input wire        deep_sleep_pin_n,
  input wire        chip_sel_n,
  input wire        out_gate_n,
  input wire        wr_strobe_n,
  input wire [16:0] flash_addr,
  input wire [7:0]  flash_dq_o,
  input wire        flash_dq_oe
);
  // Saturates at 63, which is enough to judge the 48-cycle minimum.
  reg [5:0] wake_cnt;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wake_cnt <= 6'h00;
    else if (!deep_sleep_pin_n)
      wake_cnt <= 6'h00;
    else if (wake_cnt != 6'h3F)
      wake_cnt <= wake_cnt + 6'h01;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_rd_wait;
    hsel && htrans[1] && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_wake; $fell(wr_strobe_n) |-> wake_cnt >= 6'h30; endproperty
  a_wake: assert property (p_wake)
    else $error("strobe too soon after wake");
  property p_wr_mode;
    !wr_strobe_n |-> !chip_sel_n && out_gate_n && flash_dq_oe;
  endproperty
  a_wr_mode: assert property (p_wr_mode)
    else $error("bad pins in write cycle");
  property p_no_fight;
    !out_gate_n |-> wr_strobe_n && !flash_dq_oe && !chip_sel_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("bad pins in read cycle");
  property p_wr_len;
    $fell(wr_strobe_n) |-> !wr_strobe_n [*5] ##1 wr_strobe_n;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write strobe width");
  property p_rd_len;
    $fell(out_gate_n) |-> !out_gate_n [*8] ##1 !out_gate_n [*5] ##1
      out_gate_n;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read gate width");
  property p_wr_hold;
    $rose(wr_strobe_n) |-> !chip_sel_n && flash_dq_oe &&
      $stable(flash_addr) && $stable(flash_dq_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("address or data moved at strobe rise");
  property p_sleep;
    !deep_sleep_pin_n [*2] |-> chip_sel_n && wr_strobe_n && out_gate_n &&
      !flash_dq_oe;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("pins active while asleep");
  c_wr: cover property ($rose(wr_strobe_n));
  c_rd: cover property ($rose(out_gate_n));
  c_wake: cover property ($rose(deep_sleep_pin_n));
endmodule
bind flsh_ctrl flsh_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .deep_sleep_pin_n(deep_sleep_pin_n), .chip_sel_n(chip_sel_n),
  .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe));

// *** tb/flsh_dev_mdl.sv ***
// Behavioural model of the boot-block flash seen from its pins.
// Assumes pins move on hclk edges; durations count hclk cycles.
`timescale 1ns/100ps
module flsh_dev_mdl #(
  parameter PROG_CYC  = 200,
  parameter ERASE_CYC = 900,
  parameter MAKER_ID  = 8'h5A, // Arbitrary value.
  parameter DEV_ID    = 8'hA6  // Arbitrary value.
) (
  input  wire        hclk,
  input  wire        sleep_n,
  input  wire        vpp_hi,
  input  wire        cs_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire [16:0] addr,
  input  wire [7:0]  din,
  output wire [7:0]  dout,
  output wire        drv
);
  reg [7:0]  mem [0:15];
  reg [7:0]  pend, last;
  reg [5:3]  err;
  reg [1:0]  mode;
  reg [11:0] busy;
  reg        susp, we_q;
  integer    i;
  wire       rdy = busy == 12'h000 || susp;
  wire [7:0] sr = {rdy, susp, err, 3'h0};
  wire [7:0] id = addr == 17'h00001 ? DEV_ID : MAKER_ID;
  wire [7:0] rd = mode == 2'h1 ? sr : mode == 2'h2 ? id : mem[addr[3:0]];
  assign drv = sleep_n & ~cs_n & ~oe_n & we_n;
  // Released lines show the inverse of the last driven byte, not a held value.
  assign dout = drv ? rd : ~last;
  initial begin
    for (i = 0; i < 16; i = i + 1)
      mem[i] = 8'hFF;
    {pend, last, err, mode, busy, susp, we_q} = 0;
  end
  always @(posedge hclk) begin
    if (drv)
      last <= rd;
    we_q <= we_n;
    if (busy != 12'h000 && !susp)
      busy <= busy - 12'h001;
    if (!sleep_n) begin
      mode <= 2'h0;
      pend <= 8'h00;
    end else if (!we_q && we_n && !cs_n) begin
      pend <= 8'h00;
      if (pend != 8'h00) begin
        mode <= 2'h1;
        err[3] <= err[3] | !vpp_hi;
        if (pend == 8'h20 && din == 8'hD0 && vpp_hi) begin
          for (i = 0; i < 16; i = i + 1)
            mem[i] <= 8'hFF;
          busy <= ERASE_CYC;
        end else if (pend == 8'h20)
          err[5] <= 1'b1;
        else if (vpp_hi) begin
          mem[addr[3:0]] <= mem[addr[3:0]] & din;
          busy <= PROG_CYC;
        end else
          err[4] <= 1'b1;
      end else
        case (din)
          8'hFF: mode <= 2'h0;
          8'h70: mode <= 2'h1;
          8'h50: err <= 3'h0;
          8'h90: mode <= 2'h2;
          8'h40, 8'h10, 8'h20: pend <= din;
          8'hB0, 8'hD0: begin
            susp <= din[5] && busy != 12'h000;
            mode <= 2'h1;
          end
          default: ;
        endcase
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench: AHB master, flash model and queued read checks.
// Assumes the controller answers reads after one wait state.
`timescale 1ns/100ps
module tb_top;
  localparam PROG_CYC  = 150;
  localparam ERASE_CYC = 700;
  localparam MAKER_ID  = 8'h5A; // Arbitrary value.
  localparam DEV_ID    = 8'hA6; // Arbitrary value.
  reg         hclk, hresetn, hsel, hwrite, prev_rdy;
  reg  [1:0]  htrans;
  reg  [31:0] haddr, hwdata, rdv, t0;
  reg  [15:0] lfsr;
  reg  [63:0] note_q[$];
  reg  [63:0] note;
  reg  [7:0]  d1;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, sleep_n, vpp_hi, unl, cs_n, oe_n, we_n;
  wire        dq_oe, m_oe;
  wire [16:0] fa;
  wire [7:0]  dq_o, m_dq, dq_i;
  integer     error_cnt, check_count, i;
  assign dq_i = dq_oe ? dq_o : m_dq;
  flsh_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .deep_sleep_pin_n(sleep_n), .program_supply_high_level(vpp_hi),
    .unlock_high_voltage(unl), .chip_sel_n(cs_n), .out_gate_n(oe_n),
    .wr_strobe_n(we_n), .flash_addr(fa), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
  flsh_dev_mdl #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC),
    .MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) u_dev (.hclk(hclk),
    .sleep_n(sleep_n), .vpp_hi(vpp_hi), .cs_n(cs_n), .oe_n(oe_n),
    .we_n(we_n), .addr(fa), .din(dq_o), .dout(m_dq), .drv(m_oe));
  function [15:0] nxt(input [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task give_up;
    begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  endtask
  task chk(input string nm, input [31:0] seen, exp, msk);
    begin
      check_count = check_count + 1;
      if ((seen & msk) !== (exp & msk)) begin
        error_cnt = error_cnt + 1;
        $display("unexpected %s: expected %h seen %h", nm, exp & msk,
          seen & msk);
      end
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do begin
        @(posedge hclk);
        n = n + 1;
      end while (!hreadyout && n < 99);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin
        @(posedge hclk);
        n = n + 1;
      end while (!hreadyout && n < 99);
      rdv = hrdata;
      if (n >= 99)
        give_up;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp, msk);
    begin
      note_q.push_back({msk, exp});
      bus(1'b0, a, 32'h0);
    end
  endtask
  task run_op(input [3:0] op, input [3:0] st);
    integer k;
    begin
      k = 0;
      t0 = $time;
      bus(1'b1, 8'h0C, {28'h0, op});
      do begin
        rd(8'h0C, 32'h0, 32'h0);
        k = k + 1;
      end while (rdv[0] !== 1'b0 && k < 999);
      if (k >= 999)
        give_up;
      t0 = ($time - t0) / 10;
      rd(8'h0C, {24'h0, op, st}, 32'hFF);
    end
  endtask
  task wake(input [31:0] ctl);
    begin
      bus(1'b1, 8'h00, ctl);
      repeat (62) @(posedge hclk);
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (!prev_rdy && hreadyout && note_q.size() > 0) begin
      note = note_q.pop_front();
      chk("hrdata", hrdata, note[31:0], note[63:32]);
      chk("hresp", {31'h0, hresp}, 32'h0, 32'h1);
    end
    prev_rdy = hreadyout;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = 0;
    {hresetn, error_cnt, check_count} = 0;
    prev_rdy = 1'b1;
    lfsr = 16'hC26F;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("pins", {sleep_n, cs_n, oe_n, we_n, dq_oe, m_oe}, 32'h1C, 32'h3F);
    rd(8'h00, 32'h1, 32'hFFFFFFFF);
    rd(8'h0C, 32'h0, 32'hFF);
    bus(1'b1, 8'h14, 32'hFFFF);
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    wake(32'h0);
    rd(8'h0C, 32'h8, 32'hF);
    for (i = 0; i < 3; i = i + 1)
      run_op(i == 0 ? 4'h2 : i == 1 ? 4'h3 : 4'h7, 4'hE);
    $display("reset and refusal test done");
    for (i = 0; i < 2; i = i + 1) begin
      bus(1'b1, 8'h04, i);
      run_op(4'h8, 4'hA);
      rd(8'h10, i ? DEV_ID : MAKER_ID, 32'hFF);
    end
    $display("identity test done");
    wake(32'h6);
    rd(8'h00, 32'h6, 32'hFFFFFFFF);
    lfsr = nxt(lfsr);
    bus(1'b1, 8'h04, {16'h0, lfsr});
    d1 = 8'hFF;
    for (i = 0; i < 2; i = i + 1) begin
      lfsr = nxt(lfsr);
      d1 = d1 & lfsr[7:0];
      bus(1'b1, 8'h08, {16'h0, lfsr});
      run_op(4'h2, 4'hA);
      chk("program time", t0 >= PROG_CYC, 1, 1);
      rd(8'h10, 32'h8000, 32'hFF00);
      run_op(4'h0, 4'hA);
      run_op(4'h1, 4'hA);
      rd(8'h10, d1, 32'hFF);
    end
    run_op(4'h3, 4'hA);
    chk("erase time", t0 >= ERASE_CYC, 1, 1);
    run_op(4'h4, 4'hA);
    rd(8'h10, 32'h8000, 32'hFF00);
    run_op(4'h6, 4'hA);
    run_op(4'h7, 4'hA);
    $display("program and erase test done");
    wake(32'h0);
    bus(1'b1, 8'h08, 32'h40);
    run_op(4'h9, 4'hA);
    bus(1'b1, 8'h08, 32'h55);
    run_op(4'h9, 4'hA);
    run_op(4'h4, 4'hA);
    rd(8'h10, 32'h9800, 32'hFF00);
    run_op(4'h5, 4'hA);
    run_op(4'h4, 4'hA);
    rd(8'h10, 32'h8000, 32'hFF00);
    $display("status test done");
    bus(1'b1, 8'h00, 32'h1);
    repeat (3) @(posedge hclk);
    chk("sleep pins", {sleep_n, m_oe}, 0, 3);
    rd(8'h0C, 32'h0, 32'h8);
    wake(32'h0);
    run_op(4'h1, 4'hA);
    rd(8'h10, 32'hFF, 32'hFF);
    $display("sleep test done");
    close_out;
  end
endmodule
